/* File: src/hbm_defines.svh */
// constants of the host bus port: widths and slave wait timing
`ifndef HBM_DEFINES_SVH
`define HBM_DEFINES_SVH
`define HBM_ADDR_W      7
`define HBM_SIZE_W      2
`define HBM_DATA_W      32
`define HBM_CNT_W       2
`define HBM_WAIT_STATES 3
`endif

/* File: src/hbm_pkg.sv */
// state types of the host bus port ends
package hbm_pkg;
   typedef enum logic [2:0] {
      SL_IDLE = 3'b000,
      SL_SEL  = 3'b001,
      SL_WAIT = 3'b010,
      SL_ACK  = 3'b011,
      SL_TA   = 3'b100,
      SL_ERR  = 3'b101
   } hbm_slv_t;
   typedef enum logic [2:0] {
      AR_IDLE = 3'b000,
      AR_PRE  = 3'b001,
      AR_REQ  = 3'b010,
      AR_TAKE = 3'b011,
      AR_OWN  = 3'b100,
      AR_DONE = 3'b101
   } hbm_arb_t;
   typedef enum logic [1:0] {
      HS_IDLE = 2'b00,
      HS_TS   = 2'b01,
      HS_WAIT = 2'b10,
      HS_TA   = 2'b11
   } hbm_hst_t;
endpackage

/* File: src/hbm_if.sv */
// host bus wires between the device end and the host end
`include "hbm_defines.svh"
interface hbm_if;
   logic                   read_write;
   logic [`HBM_ADDR_W-1:0] addr;
   logic [`HBM_SIZE_W-1:0] transfer_size;
   logic                   transfer_start_n;
   logic                   chip_select_n;
   logic                   transfer_ack_n;
   logic                   burst_inhibit_n;
   logic                   slave_ack_n;
   logic                   transfer_error_ack_n;
   logic [`HBM_DATA_W-1:0] dev_data;
   logic                   dev_data_oe;
   logic [`HBM_DATA_W-1:0] host_data;
   logic                   host_data_oe;
   logic [`HBM_DATA_W-1:0] data_bus;
   logic                   bus_request_n;
   logic                   bus_grant_n;
   logic                   dev_busy_n;
   logic                   dev_busy_oe;
   logic                   host_busy_n;
   logic                   host_busy_oe;
   logic                   bus_busy_n;
   logic                   master_n;
   logic                   fetch_n;
   logic                   snoop_control_bit0;

   // shared data lines and pulled-up busy line
   assign data_bus   = dev_data_oe ? dev_data
                     : (host_data_oe ? host_data : '0);
   assign bus_busy_n = !((dev_busy_oe && !dev_busy_n)
                     || (host_busy_oe && !host_busy_n));

   modport dev (
      input  read_write, addr, transfer_size, transfer_start_n,
      input  chip_select_n, transfer_ack_n, bus_grant_n, bus_busy_n,
      input  data_bus,
      output burst_inhibit_n, slave_ack_n, transfer_error_ack_n,
      output dev_data, dev_data_oe, bus_request_n, dev_busy_n,
      output dev_busy_oe, master_n, fetch_n, snoop_control_bit0
   );
   modport host (
      output read_write, addr, transfer_size, transfer_start_n,
      output chip_select_n, transfer_ack_n, bus_grant_n,
      output host_data, host_data_oe, host_busy_n, host_busy_oe,
      input  burst_inhibit_n, slave_ack_n, transfer_error_ack_n,
      input  data_bus, bus_request_n, bus_busy_n, master_n, fetch_n,
      input  snoop_control_bit0
   );
endinterface

/* File: src/hbm_dev.sv */
// device end: register slave and host bus requester
`include "hbm_defines.svh"
// Notes on behaviour
// [R01] host drives direction, address, start, size
// [R02] sample address, size, direction at start
// [R03] accept access only with valid chip select
// [R04] burst inhibit asserted during every slave access
// [R05] host drops start strobe after first clock
// [R06] read: three wait states, then drive data
// [R07] write: host data, three waits, then acknowledge
// [R08] no error: assert slave acknowledge
// [R09] error: only error acknowledge, end next edge
// [R10] deassert whichever acknowledge was asserted
// [R11] wait for host transfer acknowledge to end
// [R12] release data drivers at read end
// [R13] fetch indicator low during instruction fetches
// [R14] bus request one clock after fetch
// [R15] normal: grant, busy free, then take ownership
// [R16] fast bit: acknowledge grant one clock sooner
// [R17] fast: own on grant regardless of busy
// [R18] first cycle on next rising edge
// [R19] storage interrupt: finish handshake, drop, interrupt
// [R20] snoop mode: request one clock after snoop
// [R21] fetch high after busy; held during retry
// [R22] reset: outputs inactive, drivers released
module hbm_dev #(
   parameter int ADDR_W = `HBM_ADDR_W,
   parameter int SIZE_W = `HBM_SIZE_W,
   parameter int DATA_W = `HBM_DATA_W
) (
   input  wire logic              mclk_i,
   input  wire logic              reset_i,
   hbm_if.dev                     bus,
   output logic [ADDR_W-1:0]      reg_addr_o,
   output logic [SIZE_W-1:0]      reg_size_o,
   output logic [DATA_W-1:0]      reg_wdata_o,
   output logic                   reg_wr_o,
   output logic                   reg_rd_o,
   input  wire logic [DATA_W-1:0] reg_rdata_i,
   input  wire logic              reg_err_i,
   input  wire logic              need_bus_i,
   input  wire logic              fetch_i,
   input  wire logic              snoop_i,
   input  wire logic              snoop_mode_i,
   input  wire logic              fast_arb_i,
   input  wire logic              scsi_int_i,
   input  wire logic              cycle_done_i,
   input  wire logic              retry_i,
   input  wire logic              fatal_err_i,
   output logic                   own_o,
   output logic                   cycle_start_o,
   output logic                   int_o
);
   localparam logic [`HBM_CNT_W-1:0] WAIT_LAST =
      `HBM_CNT_W'(`HBM_WAIT_STATES - 1);

   hbm_pkg::hbm_slv_t      slv_q, slv_d;
   hbm_pkg::hbm_arb_t      arb_q, arb_d;
   logic [`HBM_CNT_W-1:0]  cnt_q;
   logic                   rd_q;
   logic                   bi_n_q, sack_n_q, tea_n_q, doe_q;
   logic [DATA_W-1:0]      dout_q;
   logic                   br_n_q, busy_n_q, busy_oe_q, mst_n_q;
   logic                   fetch_n_q, sc0_q, abort_q, first_q;

   wire ts_seen   = !bus.transfer_start_n;
   wire cs_ok     = !bus.chip_select_n;
   wire ta_seen   = !bus.transfer_ack_n;
   wire grant     = !bus.bus_grant_n;
   wire busy_free = bus.bus_busy_n;
   wire wait_end  = (slv_q == hbm_pkg::SL_WAIT) && (cnt_q == WAIT_LAST);
   wire sel_go    = (slv_q == hbm_pkg::SL_SEL) && cs_ok;
   wire in_access = (slv_d != hbm_pkg::SL_IDLE)
                 && (slv_d != hbm_pkg::SL_SEL);
   wire drive_rd  = rd_q && ((slv_d == hbm_pkg::SL_ACK)
                 || (slv_d == hbm_pkg::SL_TA));
   wire arb_start = (arb_q == hbm_pkg::AR_IDLE)
                 && (arb_d == hbm_pkg::AR_PRE);
   wire pending   = (arb_q == hbm_pkg::AR_PRE)
                 || (arb_q == hbm_pkg::AR_REQ)
                 || (arb_q == hbm_pkg::AR_TAKE);
   wire own_d     = (arb_d == hbm_pkg::AR_OWN);
   wire req_d     = (arb_d == hbm_pkg::AR_REQ)
                 || (arb_d == hbm_pkg::AR_TAKE);

   // slave access sequencing
   always_comb begin
      slv_d = slv_q;
      unique case (slv_q)
         hbm_pkg::SL_IDLE: if (ts_seen) slv_d = hbm_pkg::SL_SEL;
         hbm_pkg::SL_SEL:  if (cs_ok) slv_d = hbm_pkg::SL_WAIT; // R03
         hbm_pkg::SL_WAIT: begin
            if (wait_end) begin
               slv_d = reg_err_i ? hbm_pkg::SL_ERR : hbm_pkg::SL_ACK; // R08
            end
         end
         hbm_pkg::SL_ACK:  begin
            slv_d = ta_seen ? hbm_pkg::SL_IDLE : hbm_pkg::SL_TA; // R10
         end
         hbm_pkg::SL_TA:   if (ta_seen) slv_d = hbm_pkg::SL_IDLE; // R11
         hbm_pkg::SL_ERR:  slv_d = hbm_pkg::SL_IDLE; // R09
         default:          slv_d = hbm_pkg::SL_IDLE;
      endcase
   end

   // arbitration sequencing
   always_comb begin
      arb_d = arb_q;
      unique case (arb_q)
         hbm_pkg::AR_IDLE: if (need_bus_i) arb_d = hbm_pkg::AR_PRE;
         hbm_pkg::AR_PRE:  arb_d = hbm_pkg::AR_REQ; // R14 R20
         hbm_pkg::AR_REQ:  begin
            if (grant && fast_arb_i) begin
               arb_d = hbm_pkg::AR_OWN; // R16 R17
            end else if (grant && busy_free) begin
               arb_d = hbm_pkg::AR_TAKE; // R15
            end
         end
         hbm_pkg::AR_TAKE: arb_d = hbm_pkg::AR_OWN; // R15
         hbm_pkg::AR_OWN:  begin
            if (abort_q || cycle_done_i) arb_d = hbm_pkg::AR_DONE; // R19
         end
         hbm_pkg::AR_DONE: begin
            if (retry_i && !fatal_err_i) begin
               arb_d = hbm_pkg::AR_PRE; // R21
            end else begin
               arb_d = hbm_pkg::AR_IDLE;
            end
         end
         default:          arb_d = hbm_pkg::AR_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         slv_q <= hbm_pkg::SL_IDLE;
         cnt_q <= '0;
      end else begin
         slv_q <= slv_d;
         cnt_q <= (slv_q == hbm_pkg::SL_WAIT) ? cnt_q + 1'b1 : '0; // R06 R07
      end
   end

   // address, size and direction caught at the start strobe
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         reg_addr_o <= '0;
         reg_size_o <= '0;
         rd_q       <= 1'b0;
      end else if (ts_seen && (slv_q == hbm_pkg::SL_IDLE)) begin
         reg_addr_o <= bus.addr; // R02
         reg_size_o <= bus.transfer_size; // R02
         rd_q       <= bus.read_write; // R02
      end
   end

   // register strobes and data
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         reg_rd_o    <= 1'b0;
         reg_wr_o    <= 1'b0;
         reg_wdata_o <= '0;
         dout_q      <= '0;
      end else begin
         reg_rd_o <= sel_go && rd_q;
         reg_wr_o <= wait_end && !reg_err_i && !rd_q; // R07
         if (wait_end && !rd_q) reg_wdata_o <= bus.data_bus; // R07
         if (wait_end && rd_q) dout_q <= reg_rdata_i; // R06
      end
   end

   // slave pin drivers
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         bi_n_q   <= 1'b1; // R22
         sack_n_q <= 1'b1;
         tea_n_q  <= 1'b1;
         doe_q    <= 1'b0;
      end else begin
         bi_n_q   <= !in_access; // R04
         sack_n_q <= slv_d != hbm_pkg::SL_ACK; // R08 R10
         tea_n_q  <= slv_d != hbm_pkg::SL_ERR; // R09 R10
         doe_q    <= drive_rd; // R06 R12
      end
   end

   // arbitration state and pin drivers
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         arb_q     <= hbm_pkg::AR_IDLE;
         own_o     <= 1'b0;
         br_n_q    <= 1'b1; // R22
         busy_n_q  <= 1'b1;
         busy_oe_q <= 1'b0;
         mst_n_q   <= 1'b1;
      end else begin
         arb_q     <= arb_d;
         own_o     <= own_d; // R15 R17
         br_n_q    <= !req_d; // R14 R15
         busy_n_q  <= !own_d; // R15 R17
         busy_oe_q <= own_d;
         mst_n_q   <= !own_d; // R15 R17
      end
   end

   // fetch indicator, snoop bit and interrupt handling
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         fetch_n_q     <= 1'b1;
         sc0_q         <= 1'b0;
         abort_q       <= 1'b0;
         first_q       <= 1'b0;
         cycle_start_o <= 1'b0;
         int_o         <= 1'b0;
      end else begin
         if (arb_start) begin
            fetch_n_q <= !fetch_i; // R13
            sc0_q     <= snoop_i && snoop_mode_i; // R20
         end else if (arb_d == hbm_pkg::AR_IDLE) begin
            fetch_n_q <= 1'b1; // R21
            sc0_q     <= 1'b0;
         end
         if (arb_d == hbm_pkg::AR_IDLE) begin
            abort_q <= 1'b0;
         end else if (pending && scsi_int_i) begin
            abort_q <= 1'b1; // R19
         end
         first_q       <= own_d && (arb_q != hbm_pkg::AR_OWN);
         cycle_start_o <= first_q && !abort_q
                       && (arb_q == hbm_pkg::AR_OWN); // R18
         int_o         <= abort_q && (arb_q == hbm_pkg::AR_OWN); // R19
      end
   end

   assign bus.burst_inhibit_n      = bi_n_q;
   assign bus.slave_ack_n          = sack_n_q;
   assign bus.transfer_error_ack_n = tea_n_q;
   assign bus.dev_data             = dout_q;
   assign bus.dev_data_oe          = doe_q;
   assign bus.bus_request_n        = br_n_q;
   assign bus.dev_busy_n           = busy_n_q;
   assign bus.dev_busy_oe          = busy_oe_q;
   assign bus.master_n             = mst_n_q;
   assign bus.fetch_n              = fetch_n_q;
   assign bus.snoop_control_bit0   = sc0_q;
endmodule

/* File: src/hbm_host.sv */
// host end: processor-side slave access master and bus arbiter
`include "hbm_defines.svh"
module hbm_host #(
   parameter int ADDR_W = `HBM_ADDR_W,
   parameter int SIZE_W = `HBM_SIZE_W,
   parameter int DATA_W = `HBM_DATA_W
) (
   input  wire logic              mclk_i,
   input  wire logic              reset_i,
   hbm_if.host                    bus,
   input  wire logic              cmd_valid_i,
   input  wire logic              cmd_read_i,
   input  wire logic [ADDR_W-1:0] cmd_addr_i,
   input  wire logic [SIZE_W-1:0] cmd_size_i,
   input  wire logic [DATA_W-1:0] cmd_wdata_i,
   output logic                   cmd_ready_o,
   output logic                   resp_valid_o,
   output logic                   resp_err_o,
   output logic [DATA_W-1:0]      resp_rdata_o,
   input  wire logic              grant_en_i,
   input  wire logic              ext_busy_i
);
   hbm_pkg::hbm_hst_t hs_q, hs_d;
   logic              rw_q, ts_n_q, cs_n_q, ta_n_q, doe_q;
   logic              gnt_n_q, hbusy_oe_q;
   logic [ADDR_W-1:0] addr_q;
   logic [SIZE_W-1:0] size_q;
   logic [DATA_W-1:0] wdata_q;

   wire accept  = (hs_q == hbm_pkg::HS_IDLE) && cmd_valid_i;
   wire err_in  = !bus.transfer_error_ack_n;
   wire ack_in  = !bus.slave_ack_n;
   wire err_end = (hs_q == hbm_pkg::HS_WAIT) && err_in;
   wire ack_hit = (hs_q == hbm_pkg::HS_WAIT) && !err_in && ack_in;
   wire busy_d  = (hs_d == hbm_pkg::HS_WAIT) || (hs_d == hbm_pkg::HS_TA);

   always_comb begin
      hs_d = hs_q;
      unique case (hs_q)
         hbm_pkg::HS_IDLE: if (cmd_valid_i) hs_d = hbm_pkg::HS_TS;
         hbm_pkg::HS_TS:   hs_d = hbm_pkg::HS_WAIT; // R05
         hbm_pkg::HS_WAIT: begin
            if (err_in) begin
               hs_d = hbm_pkg::HS_IDLE;
            end else if (ack_in) begin
               hs_d = hbm_pkg::HS_TA; // R11
            end
         end
         hbm_pkg::HS_TA:   hs_d = hbm_pkg::HS_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         hs_q    <= hbm_pkg::HS_IDLE;
         rw_q    <= 1'b0;
         addr_q  <= '0;
         size_q  <= '0;
         wdata_q <= '0;
      end else begin
         hs_q <= hs_d;
         if (accept) begin
            rw_q    <= cmd_read_i; // R01
            addr_q  <= cmd_addr_i; // R01
            size_q  <= cmd_size_i; // R01
            wdata_q <= cmd_wdata_i;
         end
      end
   end

   // strobes toward the device
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         ts_n_q      <= 1'b1;
         cs_n_q      <= 1'b1;
         ta_n_q      <= 1'b1;
         doe_q       <= 1'b0;
         cmd_ready_o <= 1'b0;
      end else begin
         ts_n_q      <= hs_d != hbm_pkg::HS_TS; // R01 R05
         cs_n_q      <= hs_d == hbm_pkg::HS_IDLE;
         ta_n_q      <= hs_d != hbm_pkg::HS_TA; // R11
         doe_q       <= busy_d && !rw_q; // R07
         cmd_ready_o <= hs_d == hbm_pkg::HS_IDLE;
      end
   end

   // answers to the user and arbiter
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         resp_valid_o <= 1'b0;
         resp_err_o   <= 1'b0;
         resp_rdata_o <= '0;
         gnt_n_q      <= 1'b1;
         hbusy_oe_q   <= 1'b0;
      end else begin
         resp_valid_o <= err_end || (hs_q == hbm_pkg::HS_TA);
         if (err_end || ack_hit) resp_err_o <= err_end;
         if (ack_hit && rw_q) resp_rdata_o <= bus.data_bus;
         gnt_n_q      <= !(grant_en_i && !bus.bus_request_n);
         hbusy_oe_q   <= ext_busy_i;
      end
   end

   assign bus.read_write       = rw_q;
   assign bus.addr             = addr_q;
   assign bus.transfer_size    = size_q;
   assign bus.transfer_start_n = ts_n_q;
   assign bus.chip_select_n    = cs_n_q;
   assign bus.transfer_ack_n   = ta_n_q;
   assign bus.host_data        = wdata_q;
   assign bus.host_data_oe     = doe_q;
   assign bus.bus_grant_n      = gnt_n_q;
   assign bus.host_busy_n      = 1'b0;
   assign bus.host_busy_oe     = hbusy_oe_q;
endmodule

/* File: verif/hbm_assertions.sv */
// checker: timing relations on the host bus port wires
module hbm_assertions (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic transfer_start_n,
   input wire logic chip_select_n,
   input wire logic transfer_ack_n,
   input wire logic burst_inhibit_n,
   input wire logic slave_ack_n,
   input wire logic transfer_error_ack_n,
   input wire logic dev_data_oe,
   input wire logic bus_request_n,
   input wire logic bus_busy_n,
   input wire logic master_n,
   input wire logic fetch_n,
   input wire logic snoop_control_bit0
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (reset_i);
   sequence s_start;
      !transfer_start_n && !chip_select_n && burst_inhibit_n;
   endsequence
   sequence s_wait3;
      (slave_ack_n && transfer_error_ack_n) [*5] ##1
      !(slave_ack_n && transfer_error_ack_n);
   endsequence
   property p_tbi;
      s_start |-> ##2 !burst_inhibit_n;
   endproperty
   property p_wait;
      s_start |-> s_wait3;
   endproperty
   property p_one;
      !(slave_ack_n && transfer_error_ack_n)
      |=> slave_ack_n && transfer_error_ack_n;
   endproperty
   property p_err;
      !transfer_error_ack_n |-> slave_ack_n ##1 burst_inhibit_n;
   endproperty
   property p_ta;
      !slave_ack_n |=> !transfer_ack_n && !burst_inhibit_n ##1 burst_inhibit_n;
   endproperty
   property p_rel;
      !transfer_ack_n |=> !dev_data_oe;
   endproperty
   property p_req;
      $fell(fetch_n) |-> ##[1:2] !bus_request_n;
   endproperty
   property p_snp;
      $rose(snoop_control_bit0) |-> ##[1:2] !bus_request_n;
   endproperty
   property p_own;
      $fell(master_n) |-> bus_request_n && !bus_busy_n;
   endproperty
   property p_ts;
      !transfer_start_n |=> transfer_start_n;
   endproperty
   a_tbi: assert property (p_tbi) else $error("burst inhibit late");
   a_wait: assert property (p_wait) else $error("wait count wrong");
   a_one: assert property (p_one) else $error("ack too long");
   a_err: assert property (p_err) else $error("error end wrong");
   a_ta: assert property (p_ta) else $error("ack end wrong");
   a_rel: assert property (p_rel) else $error("data not released");
   a_req: assert property (p_req) else $error("request late");
   a_snp: assert property (p_snp) else $error("snoop request late");
   a_own: assert property (p_own) else $error("ownership wrong");
   a_ts: assert property (p_ts) else $error("start too long");
endmodule

/* File: verif/tb_top.sv */
// testbench: both host bus port ends joined by the interface
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk_i, reset_i, cmd_valid_i, cmd_read_i, cmd_ready_o;
   logic [6:0] cmd_addr_i, reg_addr_o;
   logic [1:0] cmd_size_i, reg_size_o;
   logic [31:0] cmd_wdata_i, resp_rdata_o, reg_wdata_o, reg_rdata_i;
   logic resp_valid_o, resp_err_o, grant_en_i, ext_busy_i, reg_wr_o;
   logic reg_rd_o, reg_err_i, need_bus_i, fetch_i, snoop_i, snoop_mode_i;
   logic fast_arb_i, scsi_int_i, cycle_done_i, retry_i, fatal_err_i;
   logic own_o, cycle_start_o, int_o;
   logic [8:0] cap_a;
   logic [31:0] cap_d;
   int fails = 0, tests_run = 0, acc_n = 0, st_n = 0, in_n = 0;
   hbm_if bus();
   hbm_dev hbm_dev_i (
      .mclk_i, .reset_i, .bus, .reg_addr_o, .reg_size_o, .reg_wdata_o,
      .reg_wr_o, .reg_rd_o, .reg_rdata_i, .reg_err_i, .need_bus_i, .fetch_i,
      .snoop_i, .snoop_mode_i, .fast_arb_i, .scsi_int_i, .cycle_done_i,
      .retry_i, .fatal_err_i, .own_o, .cycle_start_o, .int_o
   );
   hbm_host hbm_host_i (
      .mclk_i, .reset_i, .bus, .cmd_valid_i, .cmd_read_i, .cmd_addr_i,
      .cmd_size_i, .cmd_wdata_i, .cmd_ready_o, .resp_valid_o, .resp_err_o,
      .resp_rdata_o, .grant_en_i, .ext_busy_i
   );
   hbm_assertions hbm_assertions_i (
      .mclk_i              (mclk_i),
      .reset_i             (reset_i),
      .transfer_start_n    (bus.transfer_start_n),
      .chip_select_n       (bus.chip_select_n),
      .transfer_ack_n      (bus.transfer_ack_n),
      .burst_inhibit_n     (bus.burst_inhibit_n),
      .slave_ack_n         (bus.slave_ack_n),
      .transfer_error_ack_n(bus.transfer_error_ack_n),
      .dev_data_oe         (bus.dev_data_oe),
      .bus_request_n       (bus.bus_request_n),
      .bus_busy_n          (bus.bus_busy_n),
      .master_n            (bus.master_n),
      .fetch_n             (bus.fetch_n),
      .snoop_control_bit0  (bus.snoop_control_bit0)
   );
   always @(posedge mclk_i) begin
      if (reg_wr_o === 1'b1 || reg_rd_o === 1'b1) begin
         acc_n <= acc_n + 1;
         cap_a <= {reg_size_o, reg_addr_o};
         cap_d <= reg_wdata_o;
      end
      if (cycle_start_o === 1'b1) st_n <= st_n + 1;
      if (int_o === 1'b1) in_n <= in_n + 1;
   end
   initial begin
      mclk_i = 1'b0;
      forever #50 mclk_i = ~mclk_i;
   end
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n = 1);
      repeat (n) @(posedge mclk_i);
      #5;
   endtask
   task automatic wait_hi(ref logic s);
      int n;
      n = 0;
      while (s !== 1'b1 && n < 40) begin
         tick();
         n++;
      end
      if (n == 40) begin
         check(32'h0, 32'h1);
         final_report();
      end
   endtask
   // one slave access from the host end, checked at its response
   task automatic acc(input logic rd, input logic err, input logic [6:0] a,
                      input logic [1:0] s, input logic [31:0] d);
      int n0;
      n0 = acc_n;
      reg_err_i = err;
      reg_rdata_i = d;
      cmd_read_i = rd;
      cmd_addr_i = a;
      cmd_size_i = s;
      cmd_wdata_i = d;
      wait_hi(cmd_ready_o);
      cmd_valid_i = 1'b1;
      tick();
      cmd_valid_i = 1'b0;
      wait_hi(resp_valid_o);
      check(resp_err_o, err);
      if (rd && !err) check(resp_rdata_o, d);
      check(acc_n - n0, rd || !err);
      if (rd || !err) check(cap_a, {s, a});
      if (!rd && !err) check(cap_d, d);
      check({bus.dev_data_oe, bus.burst_inhibit_n}, 32'h1);
      tick();
   endtask
   // one arbitration round from the device end
   task automatic arb(input logic fast, input logic busy, input logic sn,
                      input logic intr, input logic rty);
      int s0, i0;
      s0 = st_n;
      i0 = in_n;
      fast_arb_i = fast;
      ext_busy_i = busy;
      snoop_i = sn;
      snoop_mode_i = sn;
      fetch_i = !sn;
      scsi_int_i = intr;
      retry_i = rty;
      need_bus_i = 1'b1;
      tick();
      need_bus_i = 1'b0;
      check({bus.fetch_n, bus.snoop_control_bit0}, {sn, sn});
      if (busy && !fast) begin
         tick(6);
         check(own_o, 1'b0);
         ext_busy_i = 1'b0;
      end
      if (intr) begin
         wait_hi(int_o);
         tick(3);
         check(st_n - s0, 0);
         check(in_n - i0, 1);
         check({bus.master_n, bus.bus_request_n}, 32'h3);
      end else begin
         wait_hi(own_o);
         check({bus.master_n, bus.bus_busy_n, bus.bus_request_n}, 32'h1);
         ext_busy_i = 1'b0;
         tick(3);
         check(st_n - s0, 1);
         cycle_done_i = 1'b1;
         tick();
         cycle_done_i = 1'b0;
         if (rty) begin
            tick(2);
            check(bus.fetch_n, 1'b0);
            retry_i = 1'b0;
            wait_hi(own_o);
            tick(2);
            cycle_done_i = 1'b1;
            tick();
            cycle_done_i = 1'b0;
         end
         tick(3);
         check({bus.fetch_n, bus.master_n, bus.bus_busy_n}, 32'h7);
      end
      ext_busy_i = 1'b0;
      scsi_int_i = 1'b0;
      tick(2);
   endtask
   initial begin
      {cmd_valid_i, cmd_read_i, cmd_addr_i, cmd_size_i, cmd_wdata_i} = '0;
      {reg_rdata_i, reg_err_i, need_bus_i, fetch_i, snoop_i} = '0;
      {snoop_mode_i, fast_arb_i, scsi_int_i, cycle_done_i} = '0;
      {retry_i, fatal_err_i, ext_busy_i} = '0;
      grant_en_i = 1'b1;
      reset_i = 1'b1;
      tick(6);
      reset_i = 1'b0;
      tick();
      check({bus.bus_request_n, bus.bus_busy_n, bus.master_n, bus.slave_ack_n,
             bus.transfer_error_ack_n, bus.burst_inhibit_n, bus.dev_data_oe},
            32'h7E);
      $display("test reset done");
      for (int i = 0; i < 4; i++) begin
         acc(1'b0, 1'b0, 7'h7F - i[6:0], i[1:0], 32'hA5C3_0F00 + i);
         acc(1'b1, 1'b0, i[6:0], i[1:0], 32'h5A3C_F0FF - i);
      end
      $display("test slave access done");
      acc(1'b1, 1'b1, 7'h10, 2'h3, 32'hDEAD_BEEF);
      acc(1'b0, 1'b1, 7'h11, 2'h0, 32'h1234_5678);
      acc(1'b1, 1'b0, 7'h12, 2'h1, 32'hFFFF_0000);
      $display("test slave error done");
      arb(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
      arb(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
      arb(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
      arb(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
      arb(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
      arb(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
      $display("test arbitration done");
      final_report();
   end
endmodule
